// ==== logic/dmsm_defs.svh ====
`ifndef DMSM_DEFS_SVH
`define DMSM_DEFS_SVH

// A request carries the item number less this offset.
`define DMSM_SPEC_OFFSET 16'h0001

// Coil window, internal item numbers.
`define DMSM_COIL_FIRST 16'h0039
`define DMSM_COIL_LAST 16'h004e
`define DMSM_COIL_COUNT 22

// Bit positions inside the coil vector (item number minus first coil).
`define DMSM_CB_LOGIC6 0
`define DMSM_CB_CAP_WEAR 1
`define DMSM_CB_FAN_WEAR 2
`define DMSM_CB_START_CONTACT 3
`define DMSM_CB_HEATSINK_HOT 4
`define DMSM_CB_SMALL_CURRENT 5
`define DMSM_CB_SPARE_FIRST 6
`define DMSM_CB_OP_PREPARED 12
`define DMSM_CB_RUN_AHEAD 13
`define DMSM_CB_RUN_BACKWARD 14
`define DMSM_CB_FATAL 15
`define DMSM_CB_NV_WRITE 16
`define DMSM_CB_ERR_FIRST 17

// Holding registers, internal item numbers.
`define DMSM_REG_SPEED_HIGH 16'h0001
`define DMSM_REG_SPEED_LOW 16'h0002
`define DMSM_REG_STATE_DETAILED 16'h0003
`define DMSM_REG_STATE_COARSE 16'h0004
`define DMSM_REG_TIME_SETTING 16'h0100

// Reset values.
`define DMSM_SPEED_RESET 32'h00000000
`define DMSM_TIME_RESET 16'h0000

// Limits and codes.
`define DMSM_SPEED_MAX 32'h00009c40
`define DMSM_REF_SEL_SERIAL 8'h03
`define DMSM_TIME_COARSE_MIN 16'h2710
`define DMSM_TIME_DIGIT 16'h000a

// Detailed drive state codes.
`define DMSM_DST_INITIAL 4'h0
`define DMSM_DST_STOP 4'h2
`define DMSM_DST_RUN 4'h3
`define DMSM_DST_COAST 4'h4
`define DMSM_DST_JOG 4'h5
`define DMSM_DST_DC_BRAKE 4'h6
`define DMSM_DST_RETRY 4'h7
`define DMSM_DST_TRIP 4'h8
`define DMSM_DST_UNDERVOLT 4'h9

// Coarse drive state codes.
`define DMSM_CST_STOPPED 2'h0
`define DMSM_CST_RUNNING 2'h1
`define DMSM_CST_TRIPPED 2'h2

`endif

// ==== logic/dmsm_pkg.sv ====
package dmsm_pkg;
    typedef logic [15:0] dmsm_word_t;
    typedef logic [31:0] dmsm_speed_t;
    typedef enum logic [1:0] {DMSM_ANS_NONE, DMSM_ANS_OK, DMSM_ANS_REFUSED} dmsm_ans_t;
endpackage

// ==== logic/dmsm_err_latch.sv ====
`timescale 1ns/100ps
module dmsm_err_latch
    import dmsm_pkg::*;
#(
    parameter int N = 5
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [N-1:0] set_pulse,
    input wire logic fault_reset,
    output logic [N-1:0] flags
);
    logic [N-1:0] flag_r;
    logic [N-1:0] flag_nxt;

    // Set wins over the fault reset so an error in the clearing cycle is kept.
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_bit
            assign flag_nxt[g] = set_pulse[g] | (flag_r[g] & ~fault_reset); // R7 R8
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (srst) begin
            flag_r <= '0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign flags = flag_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_err_set: assert property (set_pulse[0] |=> flag_r[0]) // R7
        else $error("error flag not set");
    a_err_hold: assert property ((flag_r != '0) && !fault_reset |=> // R7
        ((flag_r & $past(flag_r)) == $past(flag_r)))
        else $error("error flag lost without fault reset");
    a_err_clear: assert property (fault_reset && (set_pulse == '0) |=> flag_r == '0) // R8
        else $error("fault reset did not clear error flags");
endmodule // dmsm_err_latch

// ==== logic/dmsm_status_map.sv ====
`timescale 1ns/100ps
`include "dmsm_defs.svh"
// Contract
// (R1) Coil 0039 reads logic result six, 1 when on.
// (R2) Coils 003A and 003B read capacitor and fan wear-out warnings.
// (R3) Coils 003C to 003E read start contact, heatsink hot, small current.
// (R4) Coils 003F to 0044 read the six spare output states.
// (R5) Coils 0045 to 0047 read ready, running ahead, running backward.
// (R6) Coil 0048 reads fatal fault; coil 0049 reads nonvolatile write busy.
// (R7) Coils 004A to 004E latch communication errors until a fault reset.
// (R8) Fault reset clears the error flags even while the motor runs.
// (R9) Request number equals the internal item number minus one.
// (R10) Speed setpoint split high/low, 0 to 40000, written only when selector is 03.
// (R11) Register 0003 reads the detailed drive state code.
// (R12) Register 0004 reads the coarse drive state code.
// (R13) Time settings of 10000 or more drop the hundredths digit.
// (R14) Writes to read-only or unused items change nothing.
module dmsm_status_map
    import dmsm_pkg::*;
(
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic REQ_VALID,
    input wire logic REQ_IS_COIL,
    input wire logic REQ_WRITE,
    input wire logic [15:0] REQ_ADDR,
    input wire logic [15:0] REQ_WDATA,
    input wire logic LOGIC_RESULT_SIX,
    input wire logic CAPACITOR_WEAROUT_WARNING,
    input wire logic FAN_WEAROUT_WARNING,
    input wire logic STARTING_CONTACT_STATE,
    input wire logic HEATSINK_HOT_WARNING,
    input wire logic SMALL_CURRENT_FLAG,
    input wire logic [5:0] SPARE_OUTPUT,
    input wire logic OPERATION_PREPARED,
    input wire logic RUNNING_AHEAD_FLAG,
    input wire logic RUNNING_BACKWARD_FLAG,
    input wire logic FATAL_FAULT_FLAG,
    input wire logic NV_WRITE_BUSY,
    input wire logic [4:0] COMM_ERROR_PULSE,
    input wire logic FAULT_RESET,
    input wire logic [3:0] DRIVE_STATE_DETAILED,
    input wire logic [1:0] DRIVE_STATE_COARSE,
    input wire logic [7:0] REFERENCE_SOURCE_SELECT,
    output logic RSP_VALID,
    output logic RSP_REFUSED,
    output logic [15:0] RSP_DATA,
    output logic [4:0] COMM_ERROR_FLAGS,
    output logic [31:0] SPEED_SETPOINT,
    output logic [15:0] TIME_SETTING
);
    logic rsp_valid_r;
    logic rsp_refused_r;
    dmsm_word_t rsp_data_r;
    dmsm_speed_t speed_r;
    dmsm_speed_t speed_nxt;
    dmsm_word_t speed_stage_r;
    dmsm_word_t speed_stage_nxt;
    dmsm_word_t time_r;
    dmsm_word_t time_nxt;
    logic [4:0] err_flags;

    dmsm_err_latch #(
        .N(5)
    ) u_err_latch (
        .clk(CLOCK),
        .srst(SRST),
        .set_pulse(COMM_ERROR_PULSE),
        .fault_reset(FAULT_RESET),
        .flags(err_flags)
    );

    // Item number seen inside the device.
    wire dmsm_word_t item_no = REQ_ADDR + `DMSM_SPEC_OFFSET; // R9
    wire dmsm_word_t coil_off = item_no - `DMSM_COIL_FIRST;
    wire [4:0] coil_idx = coil_off[4:0];

    wire [`DMSM_COIL_COUNT-1:0] coil_vec = {
        err_flags, // R7
        NV_WRITE_BUSY, // R6
        FATAL_FAULT_FLAG, // R6
        RUNNING_BACKWARD_FLAG, // R5
        RUNNING_AHEAD_FLAG, // R5
        OPERATION_PREPARED, // R5
        SPARE_OUTPUT, // R4
        SMALL_CURRENT_FLAG, // R3
        HEATSINK_HOT_WARNING, // R3
        STARTING_CONTACT_STATE, // R3
        FAN_WEAROUT_WARNING, // R2
        CAPACITOR_WEAROUT_WARNING, // R2
        LOGIC_RESULT_SIX // R1
    };

    wire coil_hit = REQ_IS_COIL && (item_no >= `DMSM_COIL_FIRST)
        && (item_no <= `DMSM_COIL_LAST);
    wire reg_hi = !REQ_IS_COIL && (item_no == `DMSM_REG_SPEED_HIGH);
    wire reg_lo = !REQ_IS_COIL && (item_no == `DMSM_REG_SPEED_LOW);
    wire reg_det = !REQ_IS_COIL && (item_no == `DMSM_REG_STATE_DETAILED);
    wire reg_crs = !REQ_IS_COIL && (item_no == `DMSM_REG_STATE_COARSE);
    wire reg_time = !REQ_IS_COIL && (item_no == `DMSM_REG_TIME_SETTING);
    wire any_hit = coil_hit | reg_hi | reg_lo | reg_det | reg_crs | reg_time;
    wire is_rw = reg_hi | reg_lo | reg_time;

    // The setpoint is committed whole on the low half so the drive never sees
    // a torn value between the two writes.
    wire sel_serial = (REFERENCE_SOURCE_SELECT == `DMSM_REF_SEL_SERIAL); // R10
    wire dmsm_speed_t speed_cand = {speed_stage_r, REQ_WDATA};
    wire speed_ok = sel_serial && (speed_cand <= `DMSM_SPEED_MAX); // R10
    wire wr_hi = REQ_VALID && REQ_WRITE && reg_hi && sel_serial;
    wire wr_lo = REQ_VALID && REQ_WRITE && reg_lo && speed_ok;
    wire wr_time = REQ_VALID && REQ_WRITE && reg_time;

    // Above 100.0 s the setting only has tenths resolution.
    wire dmsm_word_t time_digit = REQ_WDATA % `DMSM_TIME_DIGIT;
    wire dmsm_word_t time_fixed = (REQ_WDATA >= `DMSM_TIME_COARSE_MIN) ?
        (REQ_WDATA - time_digit) : REQ_WDATA; // R13

    // Read-only, unused and rejected writes are refused and store nothing.
    wire refuse_nxt = !any_hit || (REQ_WRITE && !is_rw)
        || (REQ_WRITE && reg_hi && !sel_serial)
        || (REQ_WRITE && reg_lo && !speed_ok); // R14

    dmsm_word_t read_mux;
    always_comb begin
        read_mux = 16'h0000;
        if (coil_hit) begin
            read_mux = {15'h0000, coil_vec[coil_idx]}; // R1 R9
        end else if (reg_hi) begin
            read_mux = speed_r[31:16];
        end else if (reg_lo) begin
            read_mux = speed_r[15:0];
        end else if (reg_det) begin
            read_mux = {12'h000, DRIVE_STATE_DETAILED}; // R11
        end else if (reg_crs) begin
            read_mux = {14'h0000, DRIVE_STATE_COARSE}; // R12
        end else if (reg_time) begin
            read_mux = time_r;
        end
    end

    assign speed_stage_nxt = wr_hi ? REQ_WDATA : speed_stage_r;
    assign speed_nxt = wr_lo ? speed_cand : speed_r; // R10 R14
    assign time_nxt = wr_time ? time_fixed : time_r; // R13

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            speed_stage_r <= 16'h0000;
            speed_r <= `DMSM_SPEED_RESET;
            time_r <= `DMSM_TIME_RESET;
        end else begin
            speed_stage_r <= speed_stage_nxt;
            speed_r <= speed_nxt;
            time_r <= time_nxt;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            rsp_valid_r <= 1'b0;
            rsp_refused_r <= 1'b0;
            rsp_data_r <= 16'h0000;
        end else begin
            rsp_valid_r <= REQ_VALID;
            rsp_refused_r <= REQ_VALID && refuse_nxt;
            rsp_data_r <= (REQ_VALID && !REQ_WRITE) ? read_mux : 16'h0000;
        end
    end

    assign RSP_VALID = rsp_valid_r;
    assign RSP_REFUSED = rsp_refused_r;
    assign RSP_DATA = rsp_data_r;
    assign COMM_ERROR_FLAGS = err_flags;
    assign SPEED_SETPOINT = speed_r;
    assign TIME_SETTING = time_r;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SRST);

    sequence s_high_write;
        REQ_VALID && REQ_WRITE && !REQ_IS_COIL && (REQ_ADDR == 16'h0000) && sel_serial;
    endsequence

    sequence s_low_commit;
        REQ_VALID && REQ_WRITE && !REQ_IS_COIL && (REQ_ADDR == 16'h0001) && speed_ok;
    endsequence

    sequence s_no_request;
        !REQ_VALID;
    endsequence

    a_speed_pair: assert property (s_high_write ##1 s_low_commit |=> // R10
        (speed_r[31:16] == $past(REQ_WDATA, 2)) && (speed_r[15:0] == $past(REQ_WDATA)))
        else $error("speed setpoint halves not committed together");
    a_speed_spaced: assert property (s_high_write ##1 s_no_request ##1 s_low_commit |=> // R10
        (speed_r[31:16] == $past(REQ_WDATA, 3)) && (speed_r[15:0] == $past(REQ_WDATA)))
        else $error("spaced speed setpoint halves not committed together");
    a_speed_range: assert property (speed_r <= `DMSM_SPEED_MAX) // R10
        else $error("speed setpoint above limit");
    a_speed_gate: assert property ((speed_r != $past(speed_r)) && !$past(SRST) |-> // R10
        $past(REFERENCE_SOURCE_SELECT) == `DMSM_REF_SEL_SERIAL)
        else $error("speed changed while selector not serial");
    a_ro_write_keep: assert property (REQ_VALID && REQ_WRITE && !is_rw |=> // R14
        $stable(speed_r) && $stable(time_r) && RSP_REFUSED)
        else $error("write to read-only item changed state");
    a_time_trunc: assert property (wr_time && (REQ_WDATA >= `DMSM_TIME_COARSE_MIN) |=> // R13
        (time_r % `DMSM_TIME_DIGIT) == 16'h0000)
        else $error("coarse time setting kept hundredths");
    a_logic6_read: assert property (REQ_VALID && !REQ_WRITE && REQ_IS_COIL // R1
        && (REQ_ADDR == 16'h0038) |=> RSP_DATA == {15'h0000, $past(LOGIC_RESULT_SIX)})
        else $error("logic result six coil wrong");
    a_crc_read: assert property (REQ_VALID && !REQ_WRITE && REQ_IS_COIL // R7 R9
        && (REQ_ADDR == 16'h0049) |=> RSP_DATA == {15'h0000, $past(err_flags[0])})
        else $error("crc error coil wrong");
    a_detail_read: assert property (REQ_VALID && !REQ_WRITE && !REQ_IS_COIL // R11
        && (REQ_ADDR == 16'h0002) |=> RSP_DATA == {12'h000, $past(DRIVE_STATE_DETAILED)})
        else $error("detailed state register wrong");
    a_coarse_read: assert property (REQ_VALID && !REQ_WRITE && !REQ_IS_COIL // R12
        && (REQ_ADDR == 16'h0003) |=> RSP_DATA == {14'h0000, $past(DRIVE_STATE_COARSE)})
        else $error("coarse state register wrong");
    a_coil_wr_refused: assert property (REQ_VALID && REQ_WRITE && REQ_IS_COIL // R14
        |=> RSP_REFUSED)
        else $error("coil write not refused");
    a_unused_refused: assert property (REQ_VALID && !REQ_IS_COIL // R14
        && (REQ_ADDR == 16'h0004) |=> RSP_REFUSED)
        else $error("unused register not refused");
endmodule // dmsm_status_map

// ==== sim/dmsm_master_model.sv ====
`timescale 1ns/100ps
module dmsm_master_model (
    input wire logic clk,
    output logic req_valid,
    output logic req_is_coil,
    output logic req_write,
    output logic [15:0] req_addr,
    output logic [15:0] req_wdata,
    input wire logic rsp_valid,
    input wire logic rsp_refused,
    input wire logic [15:0] rsp_data
);
    initial begin
        req_valid = 1'b0;
        req_is_coil = 1'b0;
        req_write = 1'b0;
        req_addr = 16'hffff;
        req_wdata = 16'hffff;
    end
    task automatic access(input logic c, input logic w, input logic [15:0] item,
        input logic [15:0] wd, output logic [15:0] rd, output logic rf, output logic to);
        int i;
        @(posedge clk);
        req_valid <= 1'b1;
        req_is_coil <= c;
        req_write <= w;
        req_addr <= item - 16'h0001;
        req_wdata <= wd;
        @(posedge clk);
        // Released write, address and data lines flip so a design that ignores the strobe reads garbage.
        req_valid <= 1'b0;
        req_write <= ~req_write;
        req_addr <= ~req_addr;
        req_wdata <= ~req_wdata;
        to = 1'b1;
        for (i = 0; i < 4; i++) begin
            #1;
            if (rsp_valid === 1'b1) begin
                rd = rsp_data;
                rf = rsp_refused;
                to = 1'b0;
                break;
            end
            @(posedge clk);
        end
    endtask
endmodule // dmsm_master_model

// ==== sim/drive_modbus_status_map_test.sv ====
`timescale 1ns/100ps
module drive_modbus_status_map_test;
    import dmsm_pkg::*;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [16:0] st = 17'h00000;
    logic [4:0] err_pulse = 5'h00;
    logic fault_reset = 1'b0;
    logic [3:0] dst = 4'h0;
    logic [1:0] cst = 2'h0;
    logic [7:0] ref_sel = 8'h00;
    logic req_valid, req_is_coil, req_write, rsp_valid, rsp_refused, rf, to;
    logic [15:0] req_addr, req_wdata, rsp_data, time_setting, rd, hi, lo;
    logic [4:0] flags;
    logic [4:0] exp_flags = 5'h00;
    logic [15:0] rnd = 16'h0028;
    dmsm_speed_t speed, exp_speed;
    int failures = 0;
    int n_checks = 0;
    always #50 clock = ~clock;
    dmsm_status_map u_dut (.CLOCK(clock), .SRST(srst), .REQ_VALID(req_valid),
        .REQ_IS_COIL(req_is_coil), .REQ_WRITE(req_write), .REQ_ADDR(req_addr),
        .REQ_WDATA(req_wdata), .LOGIC_RESULT_SIX(st[0]), .CAPACITOR_WEAROUT_WARNING(st[1]),
        .FAN_WEAROUT_WARNING(st[2]), .STARTING_CONTACT_STATE(st[3]),
        .HEATSINK_HOT_WARNING(st[4]), .SMALL_CURRENT_FLAG(st[5]), .SPARE_OUTPUT(st[11:6]),
        .OPERATION_PREPARED(st[12]), .RUNNING_AHEAD_FLAG(st[13]),
        .RUNNING_BACKWARD_FLAG(st[14]), .FATAL_FAULT_FLAG(st[15]), .NV_WRITE_BUSY(st[16]),
        .COMM_ERROR_PULSE(err_pulse), .FAULT_RESET(fault_reset),
        .DRIVE_STATE_DETAILED(dst), .DRIVE_STATE_COARSE(cst),
        .REFERENCE_SOURCE_SELECT(ref_sel), .RSP_VALID(rsp_valid), .RSP_REFUSED(rsp_refused),
        .RSP_DATA(rsp_data), .COMM_ERROR_FLAGS(flags), .SPEED_SETPOINT(speed),
        .TIME_SETTING(time_setting));
    dmsm_master_model u_master (.clk(clock), .req_valid(req_valid),
        .req_is_coil(req_is_coil), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_refused(rsp_refused),
        .rsp_data(rsp_data));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [15:0] exp_coil(input logic [15:0] item);
        logic [21:0] cv;
        cv = {exp_flags, st};
        return {15'h0000, cv[item - 16'h0039]};
    endfunction
    function automatic logic [15:0] exp_time(input logic [15:0] v);
        return (v >= 16'h2710) ? v - (v % 16'h000a) : v;
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic acc(input logic c, input logic w, input logic [15:0] item,
        input logic [15:0] wd);
        u_master.access(c, w, item, wd, rd, rf, to);
        if (to !== 1'b0) begin
            failures++;
            stop_test();
        end
    endtask
    initial begin
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        #1;
        check("speed", speed, 32'h00000000);
        check("time", {16'h0000, time_setting}, 32'h00000000);
        $display("test reset done");
        for (int r = 0; r < 6; r++) begin
            rnd = lfsr(rnd);
            @(posedge clock);
            st <= {rnd[15] ^ rnd[0], rnd};
            for (logic [15:0] it = 16'h0038; it <= 16'h004f; it++) begin
                acc(1'b1, 1'b0, it, 16'h0000);
                if (it == 16'h0038 || it == 16'h004f) begin
                    check("coil gap", {31'h0, rf}, 32'h1);
                end else begin
                    check("coil", {rf, rd}, {1'b0, exp_coil(it)});
                    acc(1'b1, 1'b1, it, rnd);
                    check("coil wr", {31'h0, rf}, 32'h1);
                end
            end
        end
        $display("test coils done");
        for (int b = 0; b < 5; b++) begin
            @(posedge clock);
            err_pulse <= 5'h01 << b;
            st[13] <= 1'b1;
            @(posedge clock);
            err_pulse <= 5'h00;
            exp_flags[b] = 1'b1;
            acc(1'b1, 1'b0, 16'h004a + 16'(b), 16'h0000);
            check("err coil", rd, exp_coil(16'h004a + 16'(b)));
            check("flags", flags, exp_flags);
        end
        @(posedge clock);
        fault_reset <= 1'b1;
        err_pulse <= 5'h04;
        @(posedge clock);
        fault_reset <= 1'b0;
        err_pulse <= 5'h00;
        #1;
        check("set wins", flags, 5'h04);
        @(posedge clock);
        fault_reset <= 1'b1;
        @(posedge clock);
        fault_reset <= 1'b0;
        exp_flags = 5'h00;
        #1;
        check("cleared running", flags, exp_flags);
        $display("test errors done");
        for (int k = 0; k < 10; k++) begin
            if (k == 1) continue;
            @(posedge clock);
            dst <= 4'(k);
            cst <= 2'(k % 3);
            acc(1'b0, 1'b0, 16'h0003, 16'h0000);
            check("detailed", {rf, rd}, {13'h0000, 4'(k)});
            acc(1'b0, 1'b0, 16'h0004, 16'h0000);
            check("coarse", {rf, rd}, {15'h0000, 2'(k % 3)});
        end
        acc(1'b0, 1'b1, 16'h0003, 16'h0005);
        check("ro reg wr", {31'h0, rf}, 32'h1);
        acc(1'b0, 1'b0, 16'h0005, 16'h0000);
        check("reg gap", {31'h0, rf}, 32'h1);
        $display("test states done");
        @(posedge clock);
        ref_sel <= 8'h03;
        exp_speed = 32'h00000000;
        for (int t = 0; t < 8; t++) begin
            rnd = lfsr(rnd);
            hi = (t == 2) ? 16'h0001 : 16'h0000;
            lo = (t == 0) ? 16'h9c40 : (t == 1) ? 16'h9c41 : (t == 3) ? 16'h0000 : rnd;
            acc(1'b0, 1'b1, 16'h0001, hi);
            check("high wr", {31'h0, rf}, 32'h0);
            acc(1'b0, 1'b1, 16'h0002, lo);
            check("low wr", {31'h0, rf}, {31'h0, ({hi, lo} > 32'h00009c40)});
            if ({hi, lo} <= 32'h00009c40) exp_speed = {hi, lo};
            check("speed", speed, exp_speed);
        end
        @(posedge clock);
        ref_sel <= 8'h02;
        acc(1'b0, 1'b1, 16'h0002, 16'h0064);
        check("sel gate", {31'h0, rf}, 32'h1);
        check("sel keep", speed, exp_speed);
        acc(1'b0, 1'b1, 16'h0001, 16'h0001);
        check("high gate", {31'h0, rf}, 32'h1);
        acc(1'b0, 1'b0, 16'h0002, 16'h0000);
        check("low rd", rd, exp_speed[15:0]);
        acc(1'b0, 1'b0, 16'h0001, 16'h0000);
        check("high rd", {rf, rd}, {1'b0, exp_speed[31:16]});
        $display("test speed done");
        for (int t = 0; t < 5; t++) begin
            rnd = lfsr(rnd);
            hi = (t == 0) ? 16'h270f : (t == 1) ? 16'h2710 : (t == 2) ? 16'h3039 : rnd;
            acc(1'b0, 1'b1, 16'h0100, hi);
            check("time", time_setting, exp_time(hi));
            acc(1'b0, 1'b0, 16'h0100, 16'h0000);
            check("time rd", {rf, rd}, {1'b0, exp_time(hi)});
        end
        $display("test time done");
        stop_test();
    end
endmodule // drive_modbus_status_map_test
